// file: src/tua_pkg.sv
// Constants, register map and shared helpers of the timer unit
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Tick divider select codes 0..7 divide the clock by 1,2,4,8,16,64,256,1024.
// - Counter runs only while the enable bit is one; otherwise the counter stands still and the prescaler clears to zero.
// - In frequency and PWM modes a set output enable routes waveform n to its pin.
// - With auto locking, update lock stays one until enabled channels' buffers valid.
// - With auto locking, lock clears once every enabled compare buffer is valid.
// - Lock then stays clear until the next update, which copies and sets it again.
// - Without auto locking, only software changes the update lock.
// - Mode codes: 0 normal, 1 frequency, 3 one slope, 5/6/7 two slope, 2/4 reserved.
// - TOP is compare 0 in frequency mode, else top limit; update point per mode.
// - Wrap flag rises at TOP, BOTTOM or both according to the mode.
// - Plain normal counting drives no waveform out.
// - Waveform reaches a pin only when its enable is set; software sets pin direction, but the design drives wo_oe_o from the enable in wave modes.
// - Registers sit at the printed map positions, one word each.
// - Writing a compare or top buffer sets its buffer valid bit.
// - An update while the lock is zero clears all buffer valid bits.
// - While the lock is one, updates copy nothing; while zero they copy the buffers whose valid bit is set.
package tua_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLOCK_AND_RUN_CONTROL = 6'h00;
  localparam logic [5:0] IDX_WAVEFORM_AND_OUTPUT_CONTROL = 6'h01;
  localparam logic [5:0] IDX_OUTPUT_VALUE_OVERRIDE = 6'h02;
  localparam logic [5:0] IDX_DUAL_BYTE_MODE_CONTROL = 6'h03;
  localparam logic [5:0] IDX_CTRLE_CLR = 6'h04;
  localparam logic [5:0] IDX_CTRLE_SET = 6'h05;
  localparam logic [5:0] IDX_CTRLF_CLR = 6'h06;
  localparam logic [5:0] IDX_CTRLF_SET = 6'h07;
  localparam logic [5:0] IDX_EVENT_INPUT_CONTROL = 6'h09;
  localparam logic [5:0] IDX_INTEN = 6'h0a;
  localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h0b;
  localparam logic [5:0] IDX_DEBUG_HALT_CONTROL = 6'h0e;
  localparam logic [5:0] IDX_TEMP = 6'h0f;
  localparam logic [5:0] IDX_INTCLR = 6'h10;
  localparam logic [5:0] IDX_CNT = 6'h20;
  localparam logic [5:0] IDX_PER = 6'h26;
  localparam logic [5:0] IDX_COMPARE_VALUE_0 = 6'h28;
  localparam logic [5:0] IDX_COMPARE_VALUE_1 = 6'h2a;
  localparam logic [5:0] IDX_COMPARE_VALUE_2 = 6'h2c;
  localparam logic [5:0] IDX_TOP_LIMIT_BUFFER = 6'h36;
  localparam logic [5:0] IDX_TOP_LIMIT_BUFFER_HIGH = 6'h37;
  localparam logic [5:0] IDX_CMPBUF0 = 6'h38;
  localparam logic [5:0] IDX_CMPBUF1 = 6'h3a;
  localparam logic [5:0] IDX_CMPBUF2 = 6'h3c;
  // Writable bits of the byte registers
  localparam logic [7:0] MASK_CLOCK_AND_RUN_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_WAVEFORM_AND_OUTPUT_CONTROL = 8'h7f;
  localparam logic [7:0] MASK_OUTPUT_VALUE_OVERRIDE = 8'h07;
  localparam logic [7:0] MASK_DUAL_BYTE_MODE_CONTROL = 8'h01;
  localparam logic [7:0] MASK_EVENT_INPUT_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_INT = 8'h71;
  localparam logic [7:0] MASK_DBG = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int TICK_DIVIDER_SELECT_LSB = 1;
  localparam int WGM_LSB = 0;
  localparam int AUTO_UPDATE_LOCKING_BIT = 3;
  localparam int CMPEN_LSB = 4;
  localparam int DIR_BIT = 0;
  localparam int UPDATE_LOCK_BIT = 1;
  localparam int CMD_LSB = 2;
  localparam int TOP_BUFFER_VALID_BIT = 0;
  localparam int CMPBV_LSB = 1;
  localparam int OVF_BIT = 0;
  localparam int CMPF_LSB = 4;
  // Waveform mode codes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_FRQ = 3'h1;
  localparam logic [2:0] WGM_ONE_SLOPE = 3'h3;
  localparam logic [2:0] WGM_TWO_TOP = 3'h5;
  localparam logic [2:0] WGM_TWO_BOTH = 3'h6;
  localparam logic [2:0] WGM_TWO_BOTTOM = 3'h7;
  // Commands
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;

  function automatic logic [9:0] tua_div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: tua_div_mask = 10'h000;
      3'h1: tua_div_mask = 10'h001;
      3'h2: tua_div_mask = 10'h003;
      3'h3: tua_div_mask = 10'h007;
      3'h4: tua_div_mask = 10'h00f;
      3'h5: tua_div_mask = 10'h03f;
      3'h6: tua_div_mask = 10'h0ff;
      default: tua_div_mask = 10'h3ff;
    endcase
  endfunction : tua_div_mask

  function automatic logic tua_is_dual(input logic [2:0] m);
    tua_is_dual = (m == WGM_TWO_TOP) || (m == WGM_TWO_BOTH) || (m == WGM_TWO_BOTTOM);
  endfunction : tua_is_dual

  function automatic logic tua_is_wave(input logic [2:0] m);
    tua_is_wave = (m == WGM_FRQ) || (m == WGM_ONE_SLOPE) || tua_is_dual(m);
  endfunction : tua_is_wave
endpackage : tua_pkg

// file: src/tua_prescaler.sv
// Clock prescaler producing the counter tick
`timescale 1ns/1ps
module tua_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [9:0] pre;
  logic [9:0] mask;

  assign mask = tua_pkg::tua_div_mask(sel_i);
  assign tick_o = run_i && ((pre & mask) == mask);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre <= 10'h000;
    end else begin
      pre <= pre + 10'h001;
    end
  end
endmodule : tua_prescaler

// file: src/tua_timer.sv
// Timer unit top: APB registers, counter, update locking and flags
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module tua_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [2:0] wo_o,
  output logic [2:0] wo_oe_o,
  output logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [5:0] idx;
  logic wr;
  logic setup;
  logic [7:0] wb;
  logic [15:0] ww;

  assign idx = paddr_i[7:2];
  assign wr = psel_i && penable_i && pwrite_i;
  assign setup = psel_i && !penable_i;
  assign wb = pwdata_i[7:0];
  assign ww = pwdata_i[15:0];
  assign pready_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] clock_and_run_control;
  logic [7:0] waveform_and_output_control;
  logic [7:0] output_value_override;
  logic [7:0] dual_byte_mode_control;
  logic [7:0] event_input_control;
  logic [7:0] inten;
  logic [7:0] debug_halt_control;
  logic [7:0] temp;
  logic [7:0] flags;
  logic [15:0] cnt;
  logic dir;
  logic update_lock;
  logic [3:0] bv;
  logic [3:0] next_bv;
  logic [15:0] top_limit;
  logic [2:0][15:0] cmp;
  logic [15:0] top_limit_buffer;
  logic [2:0][15:0] cmpbuf;

  logic enable;
  logic auto_update_locking;
  logic [2:0] mode;
  logic [2:0] cmpen;
  logic tick;
  logic [15:0] top;
  logic at_top;
  logic at_bot;
  logic ev_top;
  logic ev_bot;
  logic update_cond;
  logic do_copy;
  logic all_valid;
  logic ovf_ev;
  logic [2:0] match;
  logic [7:0] ev;
  logic cmd_wr;
  logic [1:0] cmd;
  logic hard_rst;
  logic clr;
  logic [7:0] flag_clr;

  assign enable = clock_and_run_control[tua_pkg::ENABLE_BIT];
  assign mode = waveform_and_output_control[tua_pkg::WGM_LSB +: 3];
  assign auto_update_locking = waveform_and_output_control[tua_pkg::AUTO_UPDATE_LOCKING_BIT];
  assign cmpen = waveform_and_output_control[tua_pkg::CMPEN_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////////
  // Commands
  assign cmd_wr = wr && (idx == tua_pkg::IDX_CTRLE_SET || idx == tua_pkg::IDX_CTRLE_CLR);
  assign cmd = wb[tua_pkg::CMD_LSB +: 2];
  // Hard reset is refused while the counter runs
  assign hard_rst = cmd_wr && (cmd == tua_pkg::CMD_RESET) && !enable;
  assign clr = rst_i || hard_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // Tick, TOP and the update point
  tua_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(clr),
    .run_i(enable),
    .sel_i(clock_and_run_control[tua_pkg::TICK_DIVIDER_SELECT_LSB +: 3]),
    .tick_o(tick)
  );

  assign top = (mode == tua_pkg::WGM_FRQ) ? cmp[0] : top_limit;
  assign at_top = cnt == top;
  assign at_bot = cnt == 16'h0000;
  assign ev_top = tick && at_top && !dir;
  assign ev_bot = tick && at_bot;

  always_comb begin
    update_cond = 1'b0;
    ovf_ev = 1'b0;
    case (mode)
      tua_pkg::WGM_NORMAL, tua_pkg::WGM_FRQ: begin
        update_cond = ev_top;
        ovf_ev = ev_top;
      end
      tua_pkg::WGM_ONE_SLOPE, tua_pkg::WGM_TWO_BOTTOM: begin
        update_cond = ev_bot;
        ovf_ev = ev_bot;
      end
      tua_pkg::WGM_TWO_TOP: begin
        update_cond = ev_bot;
        ovf_ev = tick && at_top;
      end
      tua_pkg::WGM_TWO_BOTH: begin
        update_cond = ev_bot;
        ovf_ev = tick && (at_top || at_bot);
      end
      default: begin
        update_cond = 1'b0;
        ovf_ev = 1'b0;
      end
    endcase
  end

  // Copy only when unlocked, on the update point or a forced update
  assign do_copy = (update_cond || (cmd_wr && cmd == tua_pkg::CMD_UPDATE)) && !update_lock;
  assign all_valid = &(bv[tua_pkg::CMPBV_LSB +: 3] | ~cmpen);

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge clk_i) begin
    if (clr || (cmd_wr && cmd == tua_pkg::CMD_RESTART)) begin
      cnt <= tua_pkg::WORD_RESET;
      dir <= 1'b0;
    end else if (wr && idx == tua_pkg::IDX_CNT) begin
      cnt <= ww;
    end else if (wr && idx == tua_pkg::IDX_CTRLE_SET && wb[tua_pkg::DIR_BIT]) begin
      dir <= 1'b1;
    end else if (wr && idx == tua_pkg::IDX_CTRLE_CLR && wb[tua_pkg::DIR_BIT]) begin
      dir <= 1'b0;
    end else if (tick) begin
      if (tua_pkg::tua_is_dual(mode)) begin
        if (!dir && at_top) begin
          dir <= 1'b1;
          cnt <= cnt - 16'h0001;
        end else if (dir && at_bot) begin
          dir <= 1'b0;
          cnt <= cnt + 16'h0001;
        end else begin
          cnt <= dir ? cnt - 16'h0001 : cnt + 16'h0001;
        end
      end else if (!dir) begin
        cnt <= at_top ? 16'h0000 : cnt + 16'h0001;
      end else begin
        cnt <= at_bot ? top : cnt - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Update lock
  always_ff @(posedge clk_i) begin
    if (clr) begin
      update_lock <= 1'b0;
    end else if (wr && idx == tua_pkg::IDX_CTRLE_SET && wb[tua_pkg::UPDATE_LOCK_BIT]) begin
      update_lock <= 1'b1;
    end else if (wr && idx == tua_pkg::IDX_CTRLE_CLR && wb[tua_pkg::UPDATE_LOCK_BIT]) begin
      update_lock <= 1'b0;
    end else if (wr && idx == tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL && wb[tua_pkg::AUTO_UPDATE_LOCKING_BIT] && !auto_update_locking) begin
      update_lock <= 1'b1;
    end else if (auto_update_locking) begin
      if (do_copy) begin
        update_lock <= 1'b1;
      end else if (update_lock && all_valid) begin
        update_lock <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer valid bits: a buffer write wins over a clear in the same cycle
  always_comb begin
    next_bv = bv;
    if (do_copy) begin
      next_bv = 4'h0;
    end
    if (wr && idx == tua_pkg::IDX_CTRLF_CLR) begin
      next_bv = next_bv & ~wb[3:0];
    end
    if (wr && idx == tua_pkg::IDX_CTRLF_SET) begin
      next_bv = next_bv | wb[3:0];
    end
    if (wr && (idx == tua_pkg::IDX_TOP_LIMIT_BUFFER || idx == tua_pkg::IDX_TOP_LIMIT_BUFFER_HIGH)) begin
      next_bv[tua_pkg::TOP_BUFFER_VALID_BIT] = 1'b1;
    end
    for (int n = 0; n < 3; n++) begin
      if (wr && idx == tua_pkg::IDX_CMPBUF0 + 6'(2 * n)) begin
        next_bv[tua_pkg::CMPBV_LSB + n] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    bv <= clr ? 4'h0 : next_bv;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Top limit, compares and their buffers
  always_ff @(posedge clk_i) begin
    if (clr) begin
      top_limit <= tua_pkg::WORD_RESET;
      top_limit_buffer <= tua_pkg::WORD_RESET;
      cmp <= '0;
      cmpbuf <= '0;
    end else begin
      if (do_copy && bv[tua_pkg::TOP_BUFFER_VALID_BIT]) begin
        top_limit <= top_limit_buffer;
      end else if (wr && idx == tua_pkg::IDX_PER) begin
        top_limit <= ww;
      end
      if (wr && idx == tua_pkg::IDX_TOP_LIMIT_BUFFER) begin
        top_limit_buffer <= ww;
      end else if (wr && idx == tua_pkg::IDX_TOP_LIMIT_BUFFER_HIGH) begin
        top_limit_buffer[15:8] <= wb;
      end
      for (int n = 0; n < 3; n++) begin
        if (do_copy && bv[tua_pkg::CMPBV_LSB + n]) begin
          cmp[n] <= cmpbuf[n];
        end else if (wr && idx == tua_pkg::IDX_COMPARE_VALUE_0 + 6'(2 * n)) begin
          cmp[n] <= ww;
        end
        if (wr && idx == tua_pkg::IDX_CMPBUF0 + 6'(2 * n)) begin
          cmpbuf[n] <= ww;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge clk_i) begin
    if (clr) begin
      clock_and_run_control <= tua_pkg::REG_RESET;
      waveform_and_output_control <= tua_pkg::REG_RESET;
      output_value_override <= tua_pkg::REG_RESET;
      dual_byte_mode_control <= tua_pkg::REG_RESET;
      event_input_control <= tua_pkg::REG_RESET;
      inten <= tua_pkg::REG_RESET;
      debug_halt_control <= tua_pkg::REG_RESET;
      temp <= tua_pkg::REG_RESET;
    end else if (wr) begin
      case (idx)
        tua_pkg::IDX_CLOCK_AND_RUN_CONTROL: clock_and_run_control <= wb & tua_pkg::MASK_CLOCK_AND_RUN_CONTROL;
        tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL: waveform_and_output_control <= wb & tua_pkg::MASK_WAVEFORM_AND_OUTPUT_CONTROL;
        tua_pkg::IDX_OUTPUT_VALUE_OVERRIDE: output_value_override <= wb & tua_pkg::MASK_OUTPUT_VALUE_OVERRIDE;
        tua_pkg::IDX_DUAL_BYTE_MODE_CONTROL: dual_byte_mode_control <= wb & tua_pkg::MASK_DUAL_BYTE_MODE_CONTROL;
        tua_pkg::IDX_EVENT_INPUT_CONTROL: event_input_control <= wb & tua_pkg::MASK_EVENT_INPUT_CONTROL;
        tua_pkg::IDX_INTEN: inten <= wb & tua_pkg::MASK_INT;
        tua_pkg::IDX_DEBUG_HALT_CONTROL: debug_halt_control <= wb & tua_pkg::MASK_DBG;
        tua_pkg::IDX_TEMP: temp <= wb;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt; a new event beats a clear
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      match[n] = tick && (cnt == cmp[n]);
    end
  end

  assign ev = {1'b0, match, 3'h0, ovf_ev};
  assign flag_clr = (wr && (idx == tua_pkg::IDX_INTERRUPT_FLAGS || idx == tua_pkg::IDX_INTCLR))
                    ? wb : 8'h00;

  always_ff @(posedge clk_i) begin
    if (clr) begin
      flags <= tua_pkg::REG_RESET;
    end else begin
      flags <= ((flags & ~flag_clr) | ev) & tua_pkg::MASK_INT;
    end
  end

  assign irq_o = |(flags & inten);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, sampled in the setup cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= 1'b0;
      case (idx)
        tua_pkg::IDX_CLOCK_AND_RUN_CONTROL: prdata_o <= {24'h0, clock_and_run_control};
        tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL: prdata_o <= {24'h0, waveform_and_output_control};
        tua_pkg::IDX_OUTPUT_VALUE_OVERRIDE: prdata_o <= {24'h0, output_value_override};
        tua_pkg::IDX_DUAL_BYTE_MODE_CONTROL: prdata_o <= {24'h0, dual_byte_mode_control};
        tua_pkg::IDX_CTRLE_CLR, tua_pkg::IDX_CTRLE_SET: prdata_o <= {30'h0, update_lock, dir};
        tua_pkg::IDX_CTRLF_CLR, tua_pkg::IDX_CTRLF_SET: prdata_o <= {28'h0, bv};
        tua_pkg::IDX_EVENT_INPUT_CONTROL: prdata_o <= {24'h0, event_input_control};
        tua_pkg::IDX_INTEN: prdata_o <= {24'h0, inten};
        tua_pkg::IDX_INTERRUPT_FLAGS: prdata_o <= {24'h0, flags};
        tua_pkg::IDX_DEBUG_HALT_CONTROL: prdata_o <= {24'h0, debug_halt_control};
        tua_pkg::IDX_TEMP: prdata_o <= {24'h0, temp};
        tua_pkg::IDX_INTCLR: prdata_o <= 32'h0000_0000;
        tua_pkg::IDX_CNT: prdata_o <= {16'h0, cnt};
        tua_pkg::IDX_PER: prdata_o <= {16'h0, top_limit};
        tua_pkg::IDX_COMPARE_VALUE_0: prdata_o <= {16'h0, cmp[0]};
        tua_pkg::IDX_COMPARE_VALUE_1: prdata_o <= {16'h0, cmp[1]};
        tua_pkg::IDX_COMPARE_VALUE_2: prdata_o <= {16'h0, cmp[2]};
        tua_pkg::IDX_TOP_LIMIT_BUFFER: prdata_o <= {16'h0, top_limit_buffer};
        tua_pkg::IDX_TOP_LIMIT_BUFFER_HIGH: prdata_o <= {24'h0, top_limit_buffer[15:8]};
        tua_pkg::IDX_CMPBUF0: prdata_o <= {16'h0, cmpbuf[0]};
        tua_pkg::IDX_CMPBUF1: prdata_o <= {16'h0, cmpbuf[1]};
        tua_pkg::IDX_CMPBUF2: prdata_o <= {16'h0, cmpbuf[2]};
        default: begin
          prdata_o <= 32'h0000_0000;
          pslverr_o <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Waveform outputs
  tua_wavegen u_wave (
    .clk_i(clk_i),
    .rst_i(clr),
    .run_i(enable),
    .mode_i(mode),
    .cnt_i(cnt),
    .cmp_i(cmp),
    .match_i(match),
    .ovr_i(output_value_override[2:0]),
    .cmpen_i(cmpen),
    .wo_o(wo_o),
    .wo_oe_o(wo_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_idle_frozen: assert property ((!enable && !wr) |=> $stable(cnt))
    else $error("counter moved while disabled");
  chk_wrap_zero: assert property (
    (tick && mode == tua_pkg::WGM_NORMAL && !dir && at_top && !wr) |=> cnt == 16'h0000)
    else $error("counter did not wrap to zero at top");
  chk_lock_holds: assert property ((auto_update_locking && update_lock && !all_valid && !wr) |=> update_lock)
    else $error("update lock dropped early");
  chk_lock_clears: assert property (
    (auto_update_locking && update_lock && all_valid && !do_copy && !wr) |=> !update_lock)
    else $error("update lock not cleared");
  chk_lock_rearm: assert property ((auto_update_locking && do_copy && !wr) |=> update_lock)
    else $error("update lock not set after copy");
  chk_locked_nocopy: assert property ((update_lock && !wr) |=> $stable(cmp) && $stable(top_limit))
    else $error("buffers copied while locked");
  chk_bv_clear: assert property ((do_copy && !wr) |=> bv == 4'h0)
    else $error("buffer valid not cleared on update");
  chk_bv_set: assert property ((wr && idx == tua_pkg::IDX_CMPBUF1) |=> bv[2])
    else $error("buffer valid not set on write");
  chk_wrap_flag: assert property (ovf_ev |=> flags[tua_pkg::OVF_BIT])
    else $error("wrap flag not raised");
  chk_normal_quiet: assert property ((mode == tua_pkg::WGM_NORMAL) |=> wo_oe_o == 3'h0)
    else $error("waveform driven in normal mode");
  chk_oe_enable: assert property (
    (tua_pkg::tua_is_wave(mode) && !clr) |=> wo_oe_o == $past(cmpen))
    else $error("output enable does not follow channel enable");
endmodule : tua_timer

// file: src/tua_wavegen.sv
// Waveform generator and pin override for the three channels
`timescale 1ns/1ps
module tua_wavegen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] cnt_i,
  input wire logic [2:0][15:0] cmp_i,
  input wire logic [2:0] match_i,
  input wire logic [2:0] ovr_i,
  input wire logic [2:0] cmpen_i,
  output logic [2:0] wo_o,
  output logic [2:0] wo_oe_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wo_o <= 3'h0;
      wo_oe_o <= 3'h0;
    end else begin
      // Pin driven only in wave modes with the channel enabled
      wo_oe_o <= tua_pkg::tua_is_wave(mode_i) ? cmpen_i : 3'h0;
      for (int n = 0; n < 3; n++) begin
        if (!run_i) begin
          wo_o[n] <= ovr_i[n];
        end else if (mode_i == tua_pkg::WGM_FRQ) begin
          if (match_i[n]) begin
            wo_o[n] <= !wo_o[n];
          end
        end else if (tua_pkg::tua_is_wave(mode_i)) begin
          wo_o[n] <= cnt_i < cmp_i[n];
        end
      end
    end
  end
endmodule : tua_wavegen

// file: testbench/tua_timer_tb_top.sv
// Self-checking bench of the timer unit driven over its register bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tua_timer_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] wo;
  logic [2:0] wo_oe;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic serr;
  logic [31:0] cnt_a;
  logic [2:0] exp_oe;
  logic in_rng;
  int e;
  int shifts [8] = '{0, 1, 2, 3, 4, 6, 8, 10};

  tua_timer i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .wo_o(wo),
    .wo_oe_o(wo_oe),
    .irq_o(irq)
  );

  always #12.5 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // One register bus transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdr(input logic [5:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask : rdr

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(tua_pkg::IDX_CLOCK_AND_RUN_CONTROL);
    `CHK("ctrl a reset", 32'h0, rd)
    rdr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL);
    `CHK("ctrl b reset", 32'h0, rd)
    rdr(6'h08);
    `CHK("unmapped error", 1'b1, serr)
    `CHK("unmapped data", 32'h0, rd)
    wr(tua_pkg::IDX_PER, 32'h1234);
    rdr(tua_pkg::IDX_PER);
    `CHK("top limit", 32'h1234, rd)
    wr(tua_pkg::IDX_COMPARE_VALUE_1, 32'hbeef);
    rdr(tua_pkg::IDX_COMPARE_VALUE_1);
    `CHK("compare 1", 32'hbeef, rd)
    // Auto locking with channels 0 and 1 enabled
    wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h3b);
    rdr(tua_pkg::IDX_CTRLE_SET);
    `CHK("lock on", 1'b1, rd[1])
    wr(tua_pkg::IDX_CMPBUF0, 32'h3333);
    rdr(tua_pkg::IDX_CTRLF_SET);
    `CHK("valid bits", 4'h2, rd[3:0])
    rdr(tua_pkg::IDX_CTRLE_SET);
    `CHK("lock held", 1'b1, rd[1])
    wr(tua_pkg::IDX_CMPBUF1, 32'h4444);
    rdr(tua_pkg::IDX_CTRLE_SET);
    `CHK("lock released", 1'b0, rd[1])
    wr(tua_pkg::IDX_CTRLE_SET, 32'h4);
    rdr(tua_pkg::IDX_COMPARE_VALUE_0);
    `CHK("copy 0", 32'h3333, rd)
    rdr(tua_pkg::IDX_COMPARE_VALUE_1);
    `CHK("copy 1", 32'h4444, rd)
    rdr(tua_pkg::IDX_CTRLE_SET);
    `CHK("lock again", 1'b1, rd[1])
    rdr(tua_pkg::IDX_CTRLF_SET);
    `CHK("valid cleared", 4'h0, rd[3:0])
    // Manual locking only
    wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h13);
    wr(tua_pkg::IDX_CMPBUF0, 32'h5555);
    rdr(tua_pkg::IDX_CTRLE_SET);
    `CHK("lock manual", 1'b1, rd[1])
    wr(tua_pkg::IDX_CTRLE_SET, 32'h4);
    rdr(tua_pkg::IDX_COMPARE_VALUE_0);
    `CHK("locked copy", 32'h3333, rd)
    wr(tua_pkg::IDX_CTRLE_CLR, 32'h2);
    wr(tua_pkg::IDX_CTRLE_SET, 32'h4);
    rdr(tua_pkg::IDX_COMPARE_VALUE_0);
    `CHK("unlocked copy", 32'h5555, rd)
    // Pin drive per mode code
    for (int m = 0; m < 8; m++) begin
      wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h70 | m);
      exp_oe = (m == 1 || m == 3 || m >= 5) ? 3'h7 : 3'h0;
      @(negedge clk_i);
      @(negedge clk_i);
      `CHK("pin drive", exp_oe, wo_oe)
    end
    wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h03);
    @(negedge clk_i);
    @(negedge clk_i);
    `CHK("drive off", 3'h0, wo_oe)
    // Tick rate for every divider code
    wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h0);
    wr(tua_pkg::IDX_PER, 32'hffff);
    for (int s = 0; s < 8; s++) begin
      wr(tua_pkg::IDX_CNT, 32'h0);
      wr(tua_pkg::IDX_CLOCK_AND_RUN_CONTROL, {28'h0, s[2:0], 1'b1});
      repeat (2048) @(posedge clk_i);
      wr(tua_pkg::IDX_CLOCK_AND_RUN_CONTROL, 32'h0);
      rdr(tua_pkg::IDX_CNT);
      e = 2051 >> shifts[s];
      in_rng = (rd >= e - 2) && (rd <= e + 2);
      `CHK("tick rate", 1'b1, in_rng)
      cnt_a = rd;
      repeat (100) @(posedge clk_i);
      rdr(tua_pkg::IDX_CNT);
      `CHK("stopped count", cnt_a, rd)
    end
    // Frequency mode wraps at compare 0 and raises the wrap flag
    wr(tua_pkg::IDX_WAVEFORM_AND_OUTPUT_CONTROL, 32'h1);
    wr(tua_pkg::IDX_COMPARE_VALUE_0, 32'h5);
    wr(tua_pkg::IDX_CNT, 32'h0);
    wr(tua_pkg::IDX_INTEN, 32'h1);
    wr(tua_pkg::IDX_CLOCK_AND_RUN_CONTROL, 32'h1);
    for (int k = 0; k < 10; k++) begin
      rdr(tua_pkg::IDX_CNT);
      in_rng = (rd <= 32'h5);
      `CHK("count bound", 1'b1, in_rng)
    end
    wr(tua_pkg::IDX_CLOCK_AND_RUN_CONTROL, 32'h0);
    @(negedge clk_i);
    `CHK("irq raised", 1'b1, irq)
    rdr(tua_pkg::IDX_INTERRUPT_FLAGS);
    `CHK("wrap flag", 1'b1, rd[0])
    wr(tua_pkg::IDX_INTEN, 32'h0);
    @(negedge clk_i);
    `CHK("irq masked", 1'b0, irq)
    wr(tua_pkg::IDX_INTEN, 32'h1);
    wr(tua_pkg::IDX_INTERRUPT_FLAGS, 32'h1);
    @(negedge clk_i);
    `CHK("irq cleared", 1'b0, irq)
    // Stopped timer shows the override values on its outputs
    wr(tua_pkg::IDX_OUTPUT_VALUE_OVERRIDE, 32'h5);
    @(negedge clk_i);
    @(negedge clk_i);
    `CHK("override pins", 3'h5, wo)
    // Restart and hard reset commands
    wr(tua_pkg::IDX_CNT, 32'h77);
    wr(tua_pkg::IDX_CTRLE_SET, 32'h8);
    rdr(tua_pkg::IDX_CNT);
    `CHK("restart count", 32'h0, rd)
    wr(tua_pkg::IDX_CTRLE_SET, 32'hc);
    rdr(tua_pkg::IDX_PER);
    `CHK("hard reset top", 32'h0, rd)
    @(negedge clk_i);
    `CHK("hard reset pins", 3'h0, wo)
    tally_and_finish();
  end
endmodule : tua_timer_tb_top
